// ---- tb/ffrc_host_model.sv ----
// Host side of the reset and power-ok pins: pull-ups and line drivers
module ffrc_host_model (
  input  wire logic i_reset_oe,
  input  wire logic i_reset_out,
  input  wire logic i_power_oe,
  input  wire logic i_power_out,
  input  wire logic i_pull_low,
  input  wire logic i_hold_high,
  output logic      o_reset_wire,
  output logic      o_power_wire
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Pin levels
  // Pull-ups win when nobody sinks, so a released pin reads high
  assign o_power_wire = !(i_power_oe && !i_power_out);
  // Host sinks the line for an external reset
  // Strong high driver beats the device's sink
  assign o_reset_wire = i_hold_high ||
                        !((i_reset_oe && !i_reset_out) || i_pull_low);
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the fail-safe fault and reset block
`include "ffrc_params.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ffrc_pkg::*;

  localparam int REL = 30;
  localparam int LNG = 40;
  localparam int SHT = 10;
  localparam int STK = 4000;
  localparam int FLT = 1600;

  logic          i_clock = 1'b0;
  logic          i_reset_n = 1'b0;
  ffrc_apb_req_s apb_req = '0;
  ffrc_apb_rsp_s apb_rsp;
  logic [2:0]    rail_over = 3'h0;
  logic [2:0]    rail_under = 3'h0;
  logic [2:0]    pg_assign = 3'h0;
  logic          pg_link = 1'b0;
  logic          reg_corr = 1'b0;
  logic          pm_corr = 1'b0;
  logic          standby = 1'b0;
  logic          pull_low = 1'b0;
  logic          hold_high = 1'b0;
  logic          rst_wire, pg_wire, rst_out, pg_out, rst_oe, pg_oe, deep;
  int            n_errors = 0;
  int            checks_done = 0;
  int            m_tally;
  int            c;
  int            lim;
  integer        seed = 32'hBDA06300;
  logic [31:0]   rdat;
  logic          rerr;

  always #2.5 i_clock = ~i_clock;

  // Short counts keep the run small; the filter stays at full length
  ffrc_top #(.P_SC_CYC(20), .P_LONG_CYC(LNG), .P_SHORT_CYC(SHT),
    .P_REL_CYC(REL), .P_STUCK_CYC(STK)) dut_u (
    .i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_apb(apb_req), .o_apb(apb_rsp),
    .i_rail_over(rail_over), .i_rail_under(rail_under),
    .i_otp_pg_assign(pg_assign), .i_otp_pg_reset_link(pg_link),
    .i_register_corruption_flag(reg_corr),
    .i_progmem_corruption_flag(pm_corr), .i_standby(standby),
    .i_reset_out_n_in(rst_wire), .i_power_ok_n_in(pg_wire),
    .o_reset_out_n_out(rst_out), .o_reset_out_n_oe(rst_oe),
    .o_power_ok_n_out(pg_out), .o_power_ok_n_oe(pg_oe),
    .o_deep_failsafe_mode(deep));

  ffrc_host_model host_u (
    .i_reset_oe(rst_oe), .i_reset_out(rst_out),
    .i_power_oe(pg_oe), .i_power_out(pg_out),
    .i_pull_low(pull_low), .i_hold_high(hold_high),
    .o_reset_wire(rst_wire), .o_power_wire(pg_wire));

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
  endtask

  // Reads at an edge see the values sampled by that edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge i_clock);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge i_clock);
      k++;
    end
    while (apb_rsp.pready !== 1'b1 && k < 20);
    rdat = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (rst_oe !== lvl && n < 5000)
    begin
      @(posedge i_clock);
      n++;
    end
  endtask

  task automatic chk_tally();
    apb(1'b0, `FFRC_OFF_STATUS, 32'h0);
    check("tally", {28'h0, rdat[3:0]}, 32'(m_tally));
  endtask

  // Read one flag, then clear it so later reads start clean
  task automatic chk_flag(input int b);
    apb(1'b0, `FFRC_OFF_FLAGS, 32'h0);
    check("flag", {31'h0, rdat[b]}, 32'h1);
    apb(1'b1, `FFRC_OFF_FLAGS, 32'h1 << b);
  endtask

  task automatic boot(input logic [1:0] ceil, input logic [11:0] imp);
    int n;
    i_reset_n <= 1'b0;
    tick(6);
    i_reset_n <= 1'b1;
    m_tally = 1;
    wait_rst(1'b0, n);
    check("release", 32'(n >= REL && n <= REL + 4), 32'h1);
    check("deep clear", {31'h0, deep}, 32'h0);
    apb(1'b0, `FFRC_OFF_CTRL, 32'h0);
    check("ctrl", rdat & 32'h1F, 32'h15);
    apb(1'b0, `FFRC_OFF_IMPACT, 32'h0);
    check("impact", rdat, 32'h666);
    chk_tally();
    apb(1'b1, `FFRC_OFF_IMPACT, {20'h0, imp});
    apb(1'b1, `FFRC_OFF_CTRL, {27'h0, 3'b101, ceil});
    // Init phase is over, so the ceiling and impact in these two writes must not land
    apb(1'b1, `FFRC_OFF_CTRL, {27'h0, 3'b001, ~ceil});
    apb(1'b1, `FFRC_OFF_IMPACT, {20'h0, ~imp});
    apb(1'b0, `FFRC_OFF_CTRL, 32'h0);
    check("ctrl lock", rdat & 32'h1F, {27'h0, 3'b001, ceil});
    apb(1'b0, `FFRC_OFF_IMPACT, 32'h0);
    check("impact lock", rdat, {20'h0, imp});
  endtask

  // The fault that reaches the ceiling leaves reset asserted in deep mode
  task automatic corr(input logic last);
    if ($random(seed) & 1)
      reg_corr <= 1'b1;
    else
      pm_corr <= 1'b1;
    tick(2);
    reg_corr <= 1'b0;
    pm_corr <= 1'b0;
    tick(2 + ($unsigned($random(seed)) % 4));
    check("corr pins", {30'h0, rst_oe, pg_oe}, {30'h0, last, 1'b0});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    boot(2'b01, 12'h6E4);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", {rdat[30:0], rerr}, 32'h1);
    rail_over[2] <= 1'b1;
    wait_rst(1'b1, c);
    check("pg in pulse", {31'h0, pg_oe}, 32'h0);
    wait_rst(1'b0, c);
    check("long pulse", 32'(c >= LNG && c <= LNG * 11 / 9), 32'h1);
    rail_over[2] <= 1'b0;
    m_tally++;
    chk_tally();
    chk_flag(2);
    rail_over[0] <= 1'b1;
    tick(4);
    check("no reset", {31'h0, rst_oe}, 32'h0);
    rail_over[0] <= 1'b0;
    chk_tally();
    chk_flag(0);
    $display("test rail faults done");
    pg_assign <= 3'h1;
    rail_under[0] <= 1'b1;
    tick(4);
    check("pg pins", {30'h0, pg_oe, rst_oe}, 32'h3);
    rail_under[0] <= 1'b0;
    wait_rst(1'b0, c);
    check("pg free", {31'h0, pg_oe}, 32'h0);
    chk_tally();
    pg_link <= 1'b1;
    rail_under[1] <= 1'b1;
    wait_rst(1'b1, c);
    tick(1);
    check("pg linked", {31'h0, pg_oe}, 32'h1);
    wait_rst(1'b0, c);
    rail_under[1] <= 1'b0;
    pg_link <= 1'b0;
    m_tally++;
    chk_tally();
    $display("test power ok done");
    standby <= 1'b1;
    tick(4);
    check("standby pins", {30'h0, pg_oe, rst_oe}, 32'h3);
    standby <= 1'b0;
    m_tally = 1;
    wait_rst(1'b0, c);
    chk_tally();
    apb(1'b1, `FFRC_OFF_CTRL, 32'h15);
    tick(FLT + 100);
    pull_low <= 1'b1;
    tick(FLT - 50);
    chk_tally();
    tick(150);
    check("pg ext", {31'h0, pg_oe}, 32'h0);
    pull_low <= 1'b0;
    m_tally++;
    tick(FLT + 100);
    chk_tally();
    chk_flag(6);
    $display("test external reset done");
    apb(1'b1, `FFRC_OFF_CTRL, 32'h08);
    wait_rst(1'b1, c);
    check("pg sw", {31'h0, pg_oe}, 32'h0);
    wait_rst(1'b0, c);
    check("short pulse", 32'(c >= SHT && c <= SHT * 11 / 9), 32'h1);
    chk_tally();
    hold_high <= 1'b1;
    apb(1'b1, `FFRC_OFF_CTRL, 32'h0C);
    wait_rst(1'b1, c);
    wait_rst(1'b0, c);
    hold_high <= 1'b0;
    m_tally++;
    chk_tally();
    chk_flag(7);
    $display("test reset requests done");
    pull_low <= 1'b1;
    c = 0;
    while (deep !== 1'b1 && c < FLT + STK * 2)
    begin
      tick(1);
      c++;
    end
    check("stuck", 32'(c >= FLT + STK * 7 / 8 && c <= FLT + STK * 9 / 8),
          32'h1);
    pull_low <= 1'b0;
    tick(FLT + 100);
    check("deep sticky", {31'h0, deep}, 32'h1);
    $display("test stuck low done");
    for (int cc = 0; cc < 4; cc++)
    begin
      boot(cc[1:0], 12'($random(seed)));
      lim = (cc == 0) ? 2 : (cc == 1) ? 6 : (cc == 2) ? 8 : 12;
      while (m_tally + 1 < lim)
      begin
        corr(1'b0);
        m_tally++;
      end
      chk_tally();
      check("deep early", {31'h0, deep}, 32'h0);
      corr(1'b1);
      tick(2);
      check("deep ceiling", {31'h0, deep}, 32'h1);
      chk_tally();
      $display("test ceiling %0d done", lim);
    end
    conclude();
  end

  initial
  begin
    tick(40000);
    n_errors++;
    conclude();
  end
endmodule

// ---- verilog/ffrc_params.svh ----
// Offsets, field positions, reset values and timing constants
`ifndef FFRC_PARAMS_SVH
`define FFRC_PARAMS_SVH

// =============================================================
// Register offsets (byte addresses)
`define FFRC_OFF_CTRL     8'h00
`define FFRC_OFF_IMPACT   8'h04
`define FFRC_OFF_STATUS   8'h08
`define FFRC_OFF_FLAGS    8'h0C

// =============================================================
// Control register fields
`define FFRC_CTRL_CEIL_LSB   0
`define FFRC_CTRL_LONG_BIT   2
`define FFRC_CTRL_REQ_BIT    3
`define FFRC_CTRL_DONE_BIT   4

// =============================================================
// Reset values
`define FFRC_RST_CEIL        2'h1
`define FFRC_RST_LONG        1'h1
`define FFRC_RST_IMPACT      12'h666
`define FFRC_RST_TALLY       4'h1

// =============================================================
// Tally ceilings
`define FFRC_CEIL_00         4'h2
`define FFRC_CEIL_01         4'h6
`define FFRC_CEIL_10         4'h8
`define FFRC_CEIL_11         4'hC

// =============================================================
// Times, clock period and derived counts
`define FFRC_CLK_NS          5
`define FFRC_T_FB_NS         8000
`define FFRC_T_SC_NS         500000
`define FFRC_T_LONG_NS       9000000
`define FFRC_T_SHORT_NS      900000
`define FFRC_T_REL_NS        8000000
`define FFRC_T_STUCK_US      8000000
`define FFRC_FB_CYC  ((`FFRC_T_FB_NS + `FFRC_CLK_NS - 1) / `FFRC_CLK_NS)

`endif

// ---- verilog/ffrc_pkg.sv ----
// Types shared by the fail-safe fault and reset control block
package ffrc_pkg;

  // =============================================================
  // Sequencer states
  typedef enum logic [5:0] {
    ST_STBY  = 6'b000001,
    ST_WAKE  = 6'b000010,
    ST_RUN   = 6'b000100,
    ST_PULSE = 6'b001000,
    ST_EXT   = 6'b010000,
    ST_DEEP  = 6'b100000
  } ffrc_state_e;

  // =============================================================
  // APB carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ffrc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ffrc_apb_rsp_s;

  // =============================================================
  // Whole state of the block
  typedef struct packed {
    ffrc_state_e   state;
    logic [3:0]    tally;
    logic [1:0]    ceiling;
    logic          pulse_long;
    logic [11:0]   impact;
    logic          init_phase;
    logic [9:0]    flags;
    logic          fault_rst;
    logic          seen_high;
    logic [31:0]   cnt;
    logic [31:0]   stuck_cnt;
    logic [31:0]   sc_cnt;
    logic          sc_done;
    logic [1:0][10:0] fcnt;
    logic [1:0]    filt;
    logic [5:0]    rail_q;
    logic [1:0]    corr_q;
    logic          rst_oe;
    logic          pg_oe;
    ffrc_apb_rsp_s apb;
  } ffrc_regs_s;

endpackage

// ---- verilog/ffrc_top.sv ----
// Fail-safe fault tally, power-ok and reset pin sequencer with APB
`include "ffrc_params.svh"

module ffrc_top #(
  parameter int unsigned P_SC_CYC    = `FFRC_T_SC_NS / `FFRC_CLK_NS,
  parameter int unsigned P_LONG_CYC  = `FFRC_T_LONG_NS / `FFRC_CLK_NS,
  parameter int unsigned P_SHORT_CYC = `FFRC_T_SHORT_NS / `FFRC_CLK_NS,
  parameter int unsigned P_REL_CYC   = `FFRC_T_REL_NS / `FFRC_CLK_NS,
  parameter int unsigned P_STUCK_CYC =
    `FFRC_T_STUCK_US * (1000 / `FFRC_CLK_NS)
)(
  input  wire logic                    i_clock,
  input  wire logic                    i_reset_n,
  input  wire ffrc_pkg::ffrc_apb_req_s i_apb,
  output ffrc_pkg::ffrc_apb_rsp_s      o_apb,
  input  wire logic [2:0]              i_rail_over,
  input  wire logic [2:0]              i_rail_under,
  input  wire logic [2:0]              i_otp_pg_assign,
  input  wire logic                    i_otp_pg_reset_link,
  input  wire logic                    i_register_corruption_flag,
  input  wire logic                    i_progmem_corruption_flag,
  input  wire logic                    i_standby,
  input  wire logic                    i_reset_out_n_in,
  input  wire logic                    i_power_ok_n_in,
  output logic                         o_reset_out_n_out,
  output logic                         o_reset_out_n_oe,
  output logic                         o_power_ok_n_out,
  output logic                         o_power_ok_n_oe,
  output logic                         o_deep_failsafe_mode
);
  import ffrc_pkg::*;

  localparam logic [10:0] FB_LAST = 11'(`FFRC_FB_CYC - 1);

  ffrc_regs_s  r;
  ffrc_regs_s  next_r;
  logic [5:0]  rail;
  logic [5:0]  rail_rise;
  logic [5:0]  rst_en;
  logic [1:0]  corr_rise;
  logic        pg_fault;
  logic        rail_rst_evt;
  logic        inc;
  logic        mcu_req;
  logic        ev_other;
  logic        sc_cond;
  logic [9:0]  set_f;
  logic [9:0]  clr_f;
  logic [3:0]  ceil_val;
  logic [31:0] pulse_cyc;
  logic        acc;
  logic        wr;
  logic        active;

  // =============================================================
  // Next-state logic
  always_comb
  begin
    next_r    = r;
    set_f     = '0;
    clr_f     = '0;
    inc       = 1'b0;
    mcu_req   = 1'b0;
    rail      = {i_rail_under, i_rail_over};
    rail_rise = rail & ~r.rail_q;
    corr_rise = {i_progmem_corruption_flag, i_register_corruption_flag}
                & ~r.corr_q;
    next_r.rail_q = rail;
    next_r.corr_q = {i_progmem_corruption_flag, i_register_corruption_flag};
    active    = (r.state != ST_STBY) && (r.state != ST_DEEP);
    for (int k = 0; k < 3; k++)
    begin
      rst_en[k]     = r.impact[4 * k + 1];
      rst_en[k + 3] = r.impact[4 * k + 3];
    end
    pg_fault = |((i_rail_over | i_rail_under) & i_otp_pg_assign);
    rail_rst_evt = |(rail_rise & rst_en);
    unique case (r.ceiling)
      2'b00: ceil_val = `FFRC_CEIL_00;
      2'b01: ceil_val = `FFRC_CEIL_01;
      2'b10: ceil_val = `FFRC_CEIL_10;
      2'b11: ceil_val = `FFRC_CEIL_11;
    endcase
    pulse_cyc = r.pulse_long ? P_LONG_CYC : P_SHORT_CYC;

    // Read-back filters; the raw pin may bounce on the slow RC edge
    for (int i = 0; i < 2; i++)
    begin
      if ((i == 0 ? i_reset_out_n_in : i_power_ok_n_in) == r.filt[i])
        next_r.fcnt[i] = '0;
      else if (r.fcnt[i] == FB_LAST)
      begin
        next_r.filt[i] = ~r.filt[i];
        next_r.fcnt[i] = '0;
      end
      else
        next_r.fcnt[i] = r.fcnt[i] + 11'h1;
    end

    // APB slave: one wait cycle, answer registered
    acc = i_apb.psel && i_apb.penable;
    wr  = acc && r.apb.pready && i_apb.pwrite;
    next_r.apb.pready  = acc && !r.apb.pready;
    next_r.apb.pslverr = 1'b0;
    next_r.apb.prdata  = '0;
    if (acc && !r.apb.pready)
    begin
      unique case (i_apb.paddr)
        `FFRC_OFF_CTRL:
          next_r.apb.prdata = {27'h0, r.init_phase, 1'b0, r.pulse_long,
                               r.ceiling};
        `FFRC_OFF_IMPACT:
          next_r.apb.prdata = {20'h0, r.impact};
        `FFRC_OFF_STATUS:
          next_r.apb.prdata = {20'h0, r.filt, r.state, r.tally};
        `FFRC_OFF_FLAGS:
          next_r.apb.prdata = {22'h0, r.flags};
        default:
          next_r.apb.pslverr = 1'b1;
      endcase
    end
    if (wr && i_apb.paddr == `FFRC_OFF_CTRL)
    begin
      next_r.pulse_long = i_apb.pwdata[`FFRC_CTRL_LONG_BIT];
      mcu_req = i_apb.pwdata[`FFRC_CTRL_REQ_BIT];
      if (r.init_phase)
      begin
        next_r.ceiling = i_apb.pwdata[`FFRC_CTRL_CEIL_LSB +: 2];
        if (i_apb.pwdata[`FFRC_CTRL_DONE_BIT])
          next_r.init_phase = 1'b0;
      end
    end
    if (wr && i_apb.paddr == `FFRC_OFF_IMPACT && r.init_phase)
      next_r.impact = i_apb.pwdata[11:0];
    if (wr && i_apb.paddr == `FFRC_OFF_FLAGS)
      clr_f = i_apb.pwdata[9:0];

    // Flags for every rail fault, resetting or not, for software diagnosis
    set_f[5:0] = rail_rise;

    // Fixed-reaction faults only count; they drive a pin only once the tally enters deep mode
    if (active && |corr_rise)
    begin
      inc = 1'b1;
      set_f[9:8] = corr_rise;
    end
    sc_cond = r.rst_oe && r.filt[0];
    if (sc_cond && active)
    begin
      if (r.sc_cnt == P_SC_CYC - 1)
      begin
        if (!r.sc_done)
        begin
          inc = 1'b1;
          set_f[7] = 1'b1;
          next_r.sc_done = 1'b1;
        end
      end
      else
        next_r.sc_cnt = r.sc_cnt + 32'h1;
    end
    else
    begin
      next_r.sc_cnt = '0;
      if (!r.rst_oe)
        next_r.sc_done = 1'b0;
    end
    ev_other = inc;

    // Sequencer
    unique case (r.state)
      ST_STBY:
        if (!i_standby)
        begin
          next_r.state      = ST_WAKE;
          next_r.cnt        = '0;
          next_r.tally      = `FFRC_RST_TALLY;
          next_r.init_phase = 1'b1;
        end
      ST_WAKE:
        if (r.cnt == P_REL_CYC - 1)
        begin
          next_r.state     = ST_RUN;
          next_r.seen_high = 1'b0;
        end
        else
          next_r.cnt = r.cnt + 32'h1;
      ST_RUN:
      begin
        if (r.filt[0])
          next_r.seen_high = 1'b1;
        if (rail_rst_evt)
        begin
          inc = 1'b1;
          next_r.state     = ST_PULSE;
          next_r.fault_rst = 1'b1;
          next_r.cnt       = '0;
        end
        else if (mcu_req)
        begin
          next_r.state     = ST_PULSE;
          next_r.fault_rst = 1'b0;
          next_r.cnt       = '0;
        end
        else if (r.seen_high && !r.filt[0])
        begin
          inc = 1'b1;
          set_f[6] = 1'b1;
          next_r.state = ST_EXT;
        end
      end
      ST_PULSE:
        // A length change mid-pulse must not let the count run past the end
        if (r.cnt >= pulse_cyc - 1)
        begin
          next_r.state     = ST_RUN;
          next_r.seen_high = 1'b0;
          next_r.fault_rst = 1'b0;
        end
        else
          next_r.cnt = r.cnt + 32'h1;
      ST_EXT:
        if (r.filt[0])
          next_r.state = ST_RUN;
      ST_DEEP:
        next_r.state = ST_DEEP;
    endcase

    // Tally; the step that would reach the ceiling ends in deep mode
    if (inc && active)
    begin
      if (r.tally + 4'h1 >= ceil_val)
        next_r.state = ST_DEEP;
      else
        next_r.tally = r.tally + 4'h1;
    end

    // Stuck-low escape, measured on the filtered level
    if (!r.filt[0] && active)
    begin
      if (r.stuck_cnt == P_STUCK_CYC - 1)
        next_r.state = ST_DEEP;
      else
        next_r.stuck_cnt = r.stuck_cnt + 32'h1;
    end
    else
      next_r.stuck_cnt = '0;

    if (i_standby)
      next_r.state = ST_STBY;

    // Set wins over a same-cycle software clear
    next_r.flags = (r.flags & ~clr_f) | set_f;

    // Pin drives; power-ok never follows reset unless linked
    next_r.pg_oe = (next_r.state == ST_STBY) || pg_fault
                   || (i_otp_pg_reset_link && next_r.fault_rst
                       && next_r.state == ST_PULSE);
    next_r.rst_oe = next_r.pg_oe
                    || (next_r.state != ST_RUN
                        && next_r.state != ST_EXT);
  end

  // =============================================================
  // State register
  always_ff @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      r            <= '0;
      r.state      <= ST_STBY;
      r.tally      <= `FFRC_RST_TALLY;
      r.ceiling    <= `FFRC_RST_CEIL;
      r.pulse_long <= `FFRC_RST_LONG;
      r.impact     <= `FFRC_RST_IMPACT;
      r.init_phase <= 1'b1;
      r.rst_oe     <= 1'b1;
      r.pg_oe      <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign o_apb                = r.apb;
  assign o_reset_out_n_out    = 1'b0;
  assign o_power_ok_n_out     = 1'b0;
  assign o_reset_out_n_oe     = r.rst_oe;
  assign o_power_ok_n_oe      = r.pg_oe;
  // One-hot code: the deep bit is a flop of its own
  assign o_deep_failsafe_mode = r.state[5];

  // =============================================================
  // Checks
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  pg_forces_rst_a: assert property (o_power_ok_n_oe |-> o_reset_out_n_oe)
    else $error("power-ok low without reset low");
  stby_hold_a: assert property (i_standby |=> o_reset_out_n_oe
                                && o_power_ok_n_oe)
    else $error("pins not held low in standby");
  rail_pg_a: assert property (pg_fault && !i_standby |=> o_power_ok_n_oe)
    else $error("assigned rail fault left power-ok high");
  resume_one_a: assert property (r.state == ST_STBY && !i_standby
                                 |=> r.tally == 4'h1)
    else $error("tally not one after resume");
  mcu_pulse_a: assert property (r.state == ST_RUN && mcu_req
                                && !rail_rst_evt && !ev_other
                                && !i_standby && r.filt[0]
                                |=> r.state == ST_PULSE
                                && r.tally == $past(r.tally)
                                && !r.fault_rst)
    else $error("software pulse counted or not started");
  quiet_rail_a: assert property (r.state == ST_RUN && |rail_rise
                                 && !rail_rst_evt && !ev_other
                                 && r.filt[0] && !i_standby
                                 |=> r.tally == $past(r.tally)
                                 && ((r.flags & $past(rail_rise))
                                     == $past(rail_rise)))
    else $error("non-resetting rail fault changed tally");
  ceil_deep_a: assert property (inc && active && !i_standby
                                && (r.tally + 4'h1 >= ceil_val)
                                |=> r.state == ST_DEEP
                                && o_deep_failsafe_mode ##1
                                o_reset_out_n_oe)
    else $error("ceiling reached without deep fail-safe");
  rail_count_a: assert property (r.state == ST_RUN && rail_rst_evt
                                 && !i_standby
                                 && (r.tally + 4'h1 < ceil_val)
                                 |=> r.tally == $past(r.tally) + 4'h1
                                 && o_reset_out_n_oe)
    else $error("resetting rail fault not counted");
  stuck_deep_a: assert property (r.stuck_cnt == P_STUCK_CYC - 1
                                 && !r.filt[0] && active && !i_standby
                                 |=> r.state == ST_DEEP)
    else $error("stuck-low timer did not enter deep mode");
  link_pg_a: assert property (i_otp_pg_reset_link && rail_rst_evt
                              && r.state == ST_RUN && !i_standby
                              && (r.tally + 4'h1 < ceil_val)
                              |=> o_power_ok_n_oe)
    else $error("linked fault reset left power-ok high");
  pulse_bound_a: assert property (r.state == ST_PULSE
                                  |-> r.cnt < pulse_cyc)
    else $error("reset pulse ran past its length");

  pulse_c: cover property (r.state == ST_PULSE ##1 r.state == ST_RUN);
  ext_c:   cover property (r.state == ST_EXT);
  deep_c:  cover property ($rose(o_deep_failsafe_mode));
endmodule
